// ==== tcs_map.svh ====
// register map, field positions, reset values and divider counts
// assumes an APB slave with word-aligned registers, byte address = index * 4
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH
// register indices
`define TCS_CTL_IDX 10'h088
`define TCS_CKS_IDX 10'h08e
`define TCS_AUX_IDX 10'h08f
`define TCS_BIT_IDX 10'h090
// reset values
`define TCS_CTL_RST 8'h00
`define TCS_CKS_RST 8'h00
`define TCS_AUX_RST 8'h00
// run and irq control fields
`define TCS_OVF1 7
`define TCS_RUN1 6
`define TCS_OVF0 5
`define TCS_RUN0 4
`define TCS_XF1 3
`define TCS_XT1 2
`define TCS_XF0 1
`define TCS_XT0 0
// clock select fields
`define TCS_T3H 7
`define TCS_T3L 6
`define TCS_T2H 5
`define TCS_T2L 4
`define TCS_T1S 3
`define TCS_T0S 2
`define TCS_PS_HI 1
`define TCS_PS_LO 0
// auxiliary configuration fields
`define TCS_A_CM0 0
`define TCS_A_GT0 1
`define TCS_A_CM1 2
`define TCS_A_GT1 3
`define TCS_A_PL0 4
`define TCS_A_PL1 5
`define TCS_A_X2 6
`define TCS_A_X3 7
// bit operation register fields
`define TCS_BIT_VAL 8
// divider terminal counts
`define TCS_DIV12_LAST 4'hb
`define TCS_DIV4_LAST 2'h3
`define TCS_DIV48_LAST 6'h2f
`define TCS_EXT8_LAST 3'h7
`endif

// ==== tcs_pkg.sv ====
// types shared by the timer clock select and control block
// assumes the map header for numeric constants
`default_nettype none
package tcs_pkg;
  typedef enum logic [1:0] {PS_DIV12, PS_DIV4, PS_DIV48, PS_EXT8} tcs_presc_t;
  typedef struct packed {
    logic t1;
    logic t0;
    logic irq_b;
    logic irq_a;
    logic ext_clk;
  } tcs_pins_t;
  typedef struct packed {
    logic tmr1;
    logic tmr0;
    logic irq1;
    logic irq0;
  } tcs_ack_t;
  typedef struct packed {
    logic t1_ovf;
    logic t0_ovf;
    logic x1_flag;
    logic x0_flag;
  } tcs_flags_t;
  typedef struct packed {
    logic t0;
    logic t1;
    logic t2_lo;
    logic t2_hi;
    logic t3_lo;
    logic t3_hi;
  } tcs_ticks_t;
endpackage
`default_nettype wire

// ==== tcs_sync.sv ====
// three-stage pin synchroniser with agreement filter, one per bit
// assumes asynchronous inputs and one system clock
`timescale 1ns/100ps
`default_nettype none
module tcs_sync #(
  parameter int W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q, s2_q, s3_q, f_q, f_d;
      always_comb begin
        f_d = (s2_q == s3_q) ? s3_q : f_q;
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          // pins idle high behind pull-ups: no false edge after reset
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          f_q <= 1'b1;
        end else begin
          s1_q <= din[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          f_q <= f_d;
        end
      end
      assign dout[i] = f_q;
    end
  endgenerate
endmodule // tcs_sync
`default_nettype wire

// ==== tcs_top.sv ====
// timer clock selection, run control, overflow and external irq flags
// assumes an APB master on pclk and timer datapaths that use the ticks
//
// Behaviour
// R1: clock-select bit 7 picks timer 3 high byte clock: 0 external-select, 1 sysclk.
// R2: clock-select bit 6 picks timer 3 (low byte) clock: 0 external-select, 1 sysclk.
// R3: clock-select bit 5 picks timer 2 high byte clock: 0 external-select, 1 sysclk.
// R4: clock-select bit 4 picks timer 2 (low byte) clock: 0 external-select, 1 sysclk.
// R5: clock-select bit 3: timer 1 prescaler or sysclk; ignored in counter mode.
// R6: clock-select bit 2: timer 0 prescaler or sysclk; ignored in counter mode.
// R7: prescale field: sysclk/12, /4, /48, or synchronised external clock /8.
// R8: timer 1 overflow flag set on overflow, cleared by software or vectoring.
// R9: timer 0 overflow flag set on overflow, cleared by software or vectoring.
// R10: timer 1 run bit enables timer 1 counting.
// R11: timer 0 run bit enables timer 0 counting.
// R12: irq 1 flag set on selected edge/level; vector clears only in edge mode.
// R13: irq 0 flag set on selected edge/level; vector clears only in edge mode.
// R14: irq 1 type bit: 0 level, 1 edge; polarity from its own bit.
// R15: irq 0 type bit: 1 edge; polarity from its own bit.
// R16: both clock-select and control registers reset to zero.
// R17: irq 0 type bit 0 means level sensitive.
// R18: single-bit operations on the control register touch only the addressed bits.
// R19: with gate set a timer runs only while run bit and gate input are active.
// R20: timer 2/3 external select: 0 sysclk/12, 1 external clock/8.
// R21: counter mode counts falling edges of the timer's count pin.
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "tcs_map.svh"
module tcs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tcs_pkg::tcs_pins_t pins,
  input wire tcs_pkg::tcs_ack_t vec_ack,
  input wire logic tmr0_ovf,
  input wire logic tmr1_ovf,
  output tcs_pkg::tcs_flags_t flags,
  output tcs_pkg::tcs_ticks_t ticks,
  output logic tmr0_run_en,
  output logic tmr1_run_en
);
  logic [7:0] ctl_q, ctl_d, cks_q, cks_d, aux_q, aux_d, rd_q, rd_d;
  logic [3:0] c12_q, c12_d;
  logic [1:0] c4_q, c4_d;
  logic [5:0] c48_q, c48_d;
  logic [2:0] e8_q, e8_d;
  logic [4:0] flt, prv_q;
  logic acc, wr, hit_ctl, hit_cks, hit_aux, hit_bit, hit;
  logic [7:0] bmask;
  logic act0, act1, act0_p, act1_p, set_x0, set_x1;
  logic ext_rise, t0_fall, t1_fall;
  logic d12, d4, d48, e8, ps_tick;
  tcs_pkg::tcs_presc_t ps;

  tcs_sync #(
    .W(5)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(pins),
    .dout(flt)
  );

  // bus decode
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign hit_ctl = (paddr[11:2] == `TCS_CTL_IDX);
  assign hit_cks = (paddr[11:2] == `TCS_CKS_IDX);
  assign hit_aux = (paddr[11:2] == `TCS_AUX_IDX);
  assign hit_bit = (paddr[11:2] == `TCS_BIT_IDX);
  assign hit = hit_ctl | hit_cks | hit_aux | hit_bit;
  assign pready = acc;
  assign pslverr = acc & ~hit;
  assign prdata = {24'h000000, rd_q};
  assign bmask = pwdata[7:0];

  // pin conditioning, filtered bit order: ext_clk, irq_a, irq_b, t0, t1
  assign ext_rise = flt[0] & ~prv_q[0];
  assign t0_fall = ~flt[3] & prv_q[3];
  assign t1_fall = ~flt[4] & prv_q[4];
  assign act0 = aux_q[`TCS_A_PL0] ? flt[1] : ~flt[1];
  assign act1 = aux_q[`TCS_A_PL1] ? flt[2] : ~flt[2];
  assign act0_p = aux_q[`TCS_A_PL0] ? prv_q[1] : ~prv_q[1];
  assign act1_p = aux_q[`TCS_A_PL1] ? prv_q[2] : ~prv_q[2];
  assign set_x0 = ctl_q[`TCS_XT0] ? (act0 & ~act0_p) : act0; // R13 R15 R17
  assign set_x1 = ctl_q[`TCS_XT1] ? (act1 & ~act1_p) : act1; // R12 R14

  // prescaler taps
  assign d12 = (c12_q == `TCS_DIV12_LAST);
  assign d4 = (c4_q == `TCS_DIV4_LAST);
  assign d48 = (c48_q == `TCS_DIV48_LAST);
  assign e8 = ext_rise & (e8_q == `TCS_EXT8_LAST);
  assign ps = tcs_pkg::tcs_presc_t'(cks_q[`TCS_PS_HI:`TCS_PS_LO]);

  always_comb begin
    case (ps)
      tcs_pkg::PS_DIV12: ps_tick = d12; // R7
      tcs_pkg::PS_DIV4: ps_tick = d4; // R7
      tcs_pkg::PS_DIV48: ps_tick = d48; // R7
      tcs_pkg::PS_EXT8: ps_tick = e8; // R7
      default: ps_tick = 1'b0;
    endcase
  end

  // timer clock enables
  always_comb begin
    ticks.t0 = aux_q[`TCS_A_CM0] ? t0_fall : (cks_q[`TCS_T0S] | ps_tick); // R6 R21
    ticks.t1 = aux_q[`TCS_A_CM1] ? t1_fall : (cks_q[`TCS_T1S] | ps_tick); // R5 R21
    ticks.t2_lo = cks_q[`TCS_T2L] | (aux_q[`TCS_A_X2] ? e8 : d12); // R4 R20
    ticks.t2_hi = cks_q[`TCS_T2H] | (aux_q[`TCS_A_X2] ? e8 : d12); // R3 R20
    ticks.t3_lo = cks_q[`TCS_T3L] | (aux_q[`TCS_A_X3] ? e8 : d12); // R2 R20
    ticks.t3_hi = cks_q[`TCS_T3H] | (aux_q[`TCS_A_X3] ? e8 : d12); // R1 R20
  end

  assign tmr0_run_en = ctl_q[`TCS_RUN0] & (~aux_q[`TCS_A_GT0] | act0); // R11 R19
  assign tmr1_run_en = ctl_q[`TCS_RUN1] & (~aux_q[`TCS_A_GT1] | act1); // R10 R19
  assign flags = {ctl_q[`TCS_OVF1], ctl_q[`TCS_OVF0], ctl_q[`TCS_XF1], ctl_q[`TCS_XF0]};

  // register next values
  always_comb begin
    ctl_d = ctl_q;
    cks_d = cks_q;
    aux_d = aux_q;
    rd_d = rd_q;
    if (wr && hit_ctl) begin
      ctl_d = pwdata[7:0];
    end
    if (wr && hit_bit) begin
      ctl_d = (ctl_q & ~bmask) | ({8{pwdata[`TCS_BIT_VAL]}} & bmask); // R18
    end
    if (wr && hit_cks) begin
      cks_d = pwdata[7:0];
    end
    if (wr && hit_aux) begin
      aux_d = pwdata[7:0];
    end
    if (vec_ack.tmr1) begin
      ctl_d[`TCS_OVF1] = 1'b0; // R8
    end
    if (vec_ack.tmr0) begin
      ctl_d[`TCS_OVF0] = 1'b0; // R9
    end
    if (vec_ack.irq1 && ctl_q[`TCS_XT1]) begin
      ctl_d[`TCS_XF1] = 1'b0; // R12
    end
    if (vec_ack.irq0 && ctl_q[`TCS_XT0]) begin
      ctl_d[`TCS_XF0] = 1'b0; // R13
    end
    // hardware sets win over any clear
    if (tmr1_ovf) begin
      ctl_d[`TCS_OVF1] = 1'b1; // R8
    end
    if (tmr0_ovf) begin
      ctl_d[`TCS_OVF0] = 1'b1; // R9
    end
    if (set_x1) begin
      ctl_d[`TCS_XF1] = 1'b1; // R12
    end
    if (set_x0) begin
      ctl_d[`TCS_XF0] = 1'b1; // R13
    end
    if (psel && !penable && !pwrite) begin
      if (hit_ctl) begin
        rd_d = ctl_q;
      end else if (hit_cks) begin
        rd_d = cks_q;
      end else if (hit_aux) begin
        rd_d = aux_q;
      end else begin
        rd_d = 8'h00;
      end
    end
  end

  // divider next values
  always_comb begin
    c12_d = d12 ? 4'h0 : 4'(c12_q + 4'h1);
    c4_d = 2'(c4_q + 2'h1);
    c48_d = d48 ? 6'h00 : 6'(c48_q + 6'h01);
    e8_d = ext_rise ? 3'(e8_q + 3'h1) : e8_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= `TCS_CTL_RST; // R16
      cks_q <= `TCS_CKS_RST; // R16
      aux_q <= `TCS_AUX_RST;
      rd_q <= 8'h00;
      c12_q <= 4'h0;
      c4_q <= 2'h0;
      c48_q <= 6'h00;
      e8_q <= 3'h0;
      prv_q <= 5'h1f;
    end else begin
      ctl_q <= ctl_d;
      cks_q <= cks_d;
      aux_q <= aux_d;
      rd_q <= rd_d;
      c12_q <= c12_d;
      c4_q <= c4_d;
      c48_q <= c48_d;
      e8_q <= e8_d;
      prv_q <= flt;
    end
  end

  property p_ovf1_set;
    @(posedge pclk) disable iff (!presetn)
      tmr1_ovf |=> flags.t1_ovf;
  endproperty
  a_ovf1_set: assert property (p_ovf1_set) else $error("timer1 overflow not set"); // R8

  property p_ovf0_set;
    @(posedge pclk) disable iff (!presetn)
      tmr0_ovf |=> flags.t0_ovf;
  endproperty
  a_ovf0_set: assert property (p_ovf0_set) else $error("timer0 overflow not set"); // R9

  property p_ovf0_vec;
    @(posedge pclk) disable iff (!presetn)
      vec_ack.tmr0 && !tmr0_ovf |=> !flags.t0_ovf;
  endproperty
  a_ovf0_vec: assert property (p_ovf0_vec) else $error("timer0 overflow not cleared"); // R9

  property p_run1;
    @(posedge pclk) disable iff (!presetn)
      !ctl_q[`TCS_RUN1] |-> !tmr1_run_en;
  endproperty
  a_run1: assert property (p_run1) else $error("timer1 runs while stopped"); // R10

  property p_run0;
    @(posedge pclk) disable iff (!presetn)
      !ctl_q[`TCS_RUN0] |-> !tmr0_run_en;
  endproperty
  a_run0: assert property (p_run0) else $error("timer0 runs while stopped"); // R11

  property p_timer0_gate_enable;
    @(posedge pclk) disable iff (!presetn)
      ctl_q[`TCS_RUN0] && !aux_q[`TCS_A_GT0] |-> tmr0_run_en;
  endproperty
  a_timer0_gate_enable: assert property (p_timer0_gate_enable) else $error("timer0 not enabled"); // R11 R19

  property p_timer1_gate_enable;
    @(posedge pclk) disable iff (!presetn)
      aux_q[`TCS_A_GT1] && !act1 |-> !tmr1_run_en;
  endproperty
  a_timer1_gate_enable: assert property (p_timer1_gate_enable) else $error("timer1 runs with gate closed"); // R10 R19

  property p_x1_edge;
    @(posedge pclk) disable iff (!presetn)
      ctl_q[`TCS_XT1] && act1 && !act1_p |=> flags.x1_flag;
  endproperty
  a_x1_edge: assert property (p_x1_edge) else $error("irq1 edge missed"); // R12 R14

  property p_x0_edge;
    @(posedge pclk) disable iff (!presetn)
      ctl_q[`TCS_XT0] && act0 && !act0_p |=> flags.x0_flag;
  endproperty
  a_x0_edge: assert property (p_x0_edge) else $error("irq0 edge missed"); // R13 R15

  property p_x0_lvl;
    @(posedge pclk) disable iff (!presetn)
      !ctl_q[`TCS_XT0] && act0 |=> flags.x0_flag;
  endproperty
  a_x0_lvl: assert property (p_x0_lvl) else $error("irq0 level missed"); // R13 R17

  property p_x1_lvl_vec;
    @(posedge pclk) disable iff (!presetn)
      !ctl_q[`TCS_XT1] && act1 && vec_ack.irq1 |=> flags.x1_flag;
  endproperty
  a_x1_lvl_vec: assert property (p_x1_lvl_vec) else $error("irq1 level flag lost"); // R12 R14

  property p_rst;
    @(posedge pclk) $rose(presetn) |-> (ctl_q == 8'h00) && (cks_q == 8'h00);
  endproperty
  a_rst: assert property (p_rst) else $error("registers not zero"); // R16

  property p_div4;
    @(posedge pclk) disable iff (!presetn)
      ps == tcs_pkg::PS_DIV4 && !cks_q[`TCS_T0S] && !aux_q[`TCS_A_CM0] && ticks.t0
      && !(wr && (hit_cks || hit_aux)) |=> !ticks.t0[*3] ##1 ticks.t0;
  endproperty
  a_div4: assert property (p_div4) else $error("div4 spacing wrong"); // R7

  property p_bitop;
    @(posedge pclk) disable iff (!presetn)
      wr && hit_bit && bmask == 8'h10 |=> ctl_q[`TCS_RUN1] == $past(ctl_q[`TCS_RUN1]);
  endproperty
  a_bitop: assert property (p_bitop) else $error("bit op hit other bit"); // R18

  property p_t3lo;
    @(posedge pclk) disable iff (!presetn)
      cks_q[`TCS_T3L] |-> ticks.t3_lo;
  endproperty
  a_t3lo: assert property (p_t3lo) else $error("t3 lo not on sysclk"); // R2

  property p_t3hi;
    @(posedge pclk) disable iff (!presetn)
      cks_q[`TCS_T3H] |-> ticks.t3_hi;
  endproperty
  a_t3hi: assert property (p_t3hi) else $error("t3 hi not on sysclk"); // R1

  property p_t2hi;
    @(posedge pclk) disable iff (!presetn)
      cks_q[`TCS_T2H] |-> ticks.t2_hi;
  endproperty
  a_t2hi: assert property (p_t2hi) else $error("t2 hi not on sysclk"); // R3

  property p_t2lo;
    @(posedge pclk) disable iff (!presetn)
      cks_q[`TCS_T2L] |-> ticks.t2_lo;
  endproperty
  a_t2lo: assert property (p_t2lo) else $error("t2 lo not on sysclk"); // R4

  property p_t1sys;
    @(posedge pclk) disable iff (!presetn)
      cks_q[`TCS_T1S] && !aux_q[`TCS_A_CM1] |-> ticks.t1;
  endproperty
  a_t1sys: assert property (p_t1sys) else $error("timer1 not on sysclk"); // R5

  property p_cnt0;
    @(posedge pclk) disable iff (!presetn)
      aux_q[`TCS_A_CM0] |-> ticks.t0 == t0_fall;
  endproperty
  a_cnt0: assert property (p_cnt0) else $error("counter mode tick wrong"); // R6 R21
endmodule // tcs_top
`default_nettype wire

// ==== tcs_pin_model.sv ====
// pin model: external timer clock, count pins and irq inputs
// assumes the bench sets its controls by nonblocking assignment at pclk edges
`timescale 1ns/100ps
`default_nettype none
module tcs_pin_model (
  input wire logic pclk,
  input wire logic ext_run,
  input wire logic [1:0] irq_act,
  input wire logic [1:0] irq_pol,
  input wire logic [1:0] cnt_lvl,
  output tcs_pkg::tcs_pins_t pins
);
  logic [1:0] ph_q = 2'h0;
  logic ext_q = 1'b0;
  // ext clock period 8, stands still while not running
  always @(posedge pclk) begin
    ph_q <= ext_run ? ph_q + 2'h1 : 2'h0;
    if (ext_run && ph_q == 2'h3) begin
      ext_q <= ~ext_q;
    end
  end
  assign pins = {cnt_lvl, irq_act ~^ irq_pol, ext_q};
endmodule // tcs_pin_model
`default_nettype wire

// ==== tb_timer_clock_select_and_control.sv ====
// bench: apb tasks, tick counting windows, flag and run tests
// assumes the pin model and the register map header
`timescale 1ns/100ps
`default_nettype none
`include "tcs_map.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_timer_clock_select_and_control;
  localparam logic [11:0] A_CTL = {`TCS_CTL_IDX, 2'h0};
  localparam logic [11:0] A_CKS = {`TCS_CKS_IDX, 2'h0};
  localparam logic [11:0] A_AUX = {`TCS_AUX_IDX, 2'h0};
  localparam logic [11:0] A_BIT = {`TCS_BIT_IDX, 2'h0};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tcs_pkg::tcs_pins_t pins;
  logic [5:0] ev = 6'h0;
  tcs_pkg::tcs_flags_t flags;
  tcs_pkg::tcs_ticks_t ticks;
  logic tmr0_run_en;
  logic tmr1_run_en;
  logic ext_run = 1'b0;
  logic [1:0] irq_act = 2'h0;
  logic [1:0] irq_pol = 2'h0;
  logic [1:0] cnt_lvl = 2'h3;
  logic [31:0] rd;
  logic se;
  int err_count = 0;
  int comparisons = 0;
  int tot[6] = '{default: 0};
  int s[6];
  int dif[6];
  logic [7:0] cfg[3] = '{8'ha8, 8'h55, 8'h02};
  int exp_t[3][6] = '{'{8, 96, 8, 96, 8, 96}, '{96, 24, 96, 8, 96, 8}, '{2, 2, 8, 8, 8, 8}};

  tcs_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pins, .vec_ack(ev[5:2]), .tmr0_ovf(ev[0]), .tmr1_ovf(ev[1]), .flags, .ticks,
    .tmr0_run_en, .tmr1_run_en);
  tcs_pin_model u_pins (.pclk, .ext_run, .irq_act, .irq_pol, .cnt_lvl, .pins);

  always #5 pclk = ~pclk;
  // tick totals, index 0 is timer 0
  always @(posedge pclk) begin
    for (int i = 0; i < 6; i++) begin
      tot[i] <= tot[i] + int'(ticks[5 - i]);
    end
  end

  task automatic conclude();
    $display("counts: %0d mismatches, %0d comparisons", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!(pready === 1'b1 && psel && penable) && k < 20);
    if (k >= 20) begin
      err_count++;
      conclude();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic rd_is(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  task automatic evp(input logic [5:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= 6'h0;
    @(posedge pclk);
    #1;
  endtask

  task automatic snap();
    @(posedge pclk);
    s = tot;
  endtask

  task automatic calc(input int n);
    repeat (n) @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      dif[i] = tot[i] - s[i];
    end
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_is(A_CTL, 32'h0, "ctl reset");
    rd_is(A_CKS, 32'h0, "cks reset");
    apb(1'b0, 12'h3fc, 32'h0);
    `CHK("unmapped err", 1'b1, se)
    apb(1'b1, A_AUX, 32'h0);
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, A_CKS, {24'h0, cfg[j]});
      rd_is(A_CKS, {24'h0, cfg[j]}, "cks");
      snap();
      calc(96);
      for (int i = 0; i < 6; i++) `CHK("tick", exp_t[j][i], dif[i])
    end
    apb(1'b1, A_CKS, 32'h03);
    apb(1'b1, A_AUX, 32'hc0);
    snap();
    ext_run <= 1'b1;
    repeat (128) @(posedge pclk);
    ext_run <= 1'b0;
    calc(12);
    for (int i = 0; i < 6; i++) `CHK("ext tick", 2, dif[i])
    apb(1'b1, A_AUX, 32'h05);
    apb(1'b1, A_CKS, 32'h0c);
    snap();
    for (int k = 0; k < 3; k++) begin
      cnt_lvl <= (k < 2) ? 2'h0 : 2'h2;
      repeat (8) @(posedge pclk);
      cnt_lvl <= 2'h3;
      repeat (8) @(posedge pclk);
    end
    calc(12);
    `CHK("t0 count", 3, dif[0])
    `CHK("t1 count", 2, dif[1])
    apb(1'b1, A_AUX, 32'h0);
    apb(1'b1, A_CTL, 32'h50);
    `CHK("run", 2'h3, {tmr1_run_en, tmr0_run_en})
    evp(6'h01);
    `CHK("flags", 4'h4, flags)
    evp(6'h02);
    `CHK("flags", 4'hc, flags)
    evp(6'h20);
    `CHK("flags", 4'h4, flags)
    evp(6'h10);
    `CHK("flags", 4'h0, flags)
    apb(1'b1, A_BIT, 32'h180);
    rd_is(A_CTL, 32'hd0, "bitop set");
    apb(1'b1, A_CTL, 32'h10);
    `CHK("sw clear", 6'h01, {flags, tmr1_run_en, tmr0_run_en})
    apb(1'b1, A_AUX, 32'h02);
    `CHK("gate off", 1'b0, tmr0_run_en)
    irq_act <= 2'h3;
    repeat (8) @(posedge pclk);
    #1;
    `CHK("gate on", 1'b1, tmr0_run_en)
    evp(6'h0c);
    `CHK("level flags", 4'h3, flags)
    irq_act <= 2'h0;
    repeat (8) @(posedge pclk);
    apb(1'b1, A_BIT, 32'h00a);
    `CHK("level clear", 4'h0, flags)
    irq_pol <= 2'h3;
    apb(1'b1, A_AUX, 32'h30);
    apb(1'b1, A_BIT, 32'h105);
    apb(1'b1, A_BIT, 32'h00a);
    rd_is(A_CTL, 32'h15, "edge mode");
    irq_act <= 2'h3;
    repeat (8) @(posedge pclk);
    #1;
    `CHK("edge flags", 4'h3, flags)
    evp(6'h0c);
    repeat (4) @(posedge pclk);
    `CHK("edge vec", 4'h0, flags)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_is(A_CTL, 32'h0, "ctl rereset");
    rd_is(A_CKS, 32'h0, "cks rereset");
    conclude();
  end
endmodule // tb_timer_clock_select_and_control
`default_nettype wire
